//--- rtl/cmpsel_top.sv
// Comparator input select registers on the special-function bus and their mux selects.
`timescale 1ns/1ps
`default_nettype none
`include "cmpsel_map.svh"
module cmpsel_top (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic [3:0] i_sfr_page,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit,
  output logic [10:0] o_cmp0_negative_select,
  output logic [11:0] o_cmp0_positive_select,
  output logic [10:0] o_cmp1_negative_select,
  output logic [11:0] o_cmp1_positive_select
);
  import cmpsel_pkg::*;

  // --------------------------------------------------------------
  // Bus timing
  // --------------------------------------------------------------
  // An access is taken at the rising edge that sees a strobe high.
  // Read data and the hit flag are registered, so they change at that same
  // edge and stand for exactly one cycle.
  // Outside a read the data lines rest at zero, so a shared read bus can
  // simply OR the answers of several blocks together.
  // A read and a write in the same cycle return the old register value.
  // Only page zero maps; every other page or address is ignored.

  // --------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------
  function automatic logic addr_is(input logic [3:0] page, input logic [7:0] addr,
                                   input logic [7:0] want);
    addr_is = (page == `CMPSEL_SFR_PAGE) && (addr == want);
  endfunction

  wire sel0 = addr_is(i_sfr_page, i_sfr_addr, `CMPSEL_ADDR_CMP0);
  wire sel1 = addr_is(i_sfr_page, i_sfr_addr, `CMPSEL_ADDR_CMP1);

  logic [7:0] cmp0_sel_r;
  logic [7:0] cmp1_sel_r;
  logic [7:0] cmp0_sel_nxt;
  logic [7:0] cmp1_sel_nxt;
  logic [7:0] rdata_nxt;
  logic hit_nxt;
  logic wr0_go;
  logic wr1_go;
  logic rd0_go;
  logic rd1_go;

  // Strobes qualified by the address match, one per register and direction.
  assign wr0_go = i_sfr_wr && sel0;
  assign wr1_go = i_sfr_wr && sel1;
  assign rd0_go = i_sfr_rd && sel0;
  assign rd1_go = i_sfr_rd && sel1;

  // Write path: a matching write stores the whole byte, reserved codes included.
  assign cmp0_sel_nxt = wr0_go ? i_sfr_wdata : cmp0_sel_r;
  assign cmp1_sel_nxt = wr1_go ? i_sfr_wdata : cmp1_sel_r;
  // Read path: unmapped reads return zero and no hit.
  assign rdata_nxt = rd0_go ? cmp0_sel_r : rd1_go ? cmp1_sel_r : 8'h00;
  assign hit_nxt = (i_sfr_rd || i_sfr_wr) && (sel0 || sel1);

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  // Select registers come up at all ones so both comparators see code 1111.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cmp0_sel_r <= `CMPSEL_RESET_VALUE;
      cmp1_sel_r <= `CMPSEL_RESET_VALUE;
      o_sfr_rdata <= 8'h00;
      o_sfr_hit <= 1'b0;
    end else begin
      cmp0_sel_r <= cmp0_sel_nxt;
      cmp1_sel_r <= cmp1_sel_nxt;
      o_sfr_rdata <= rdata_nxt;
      o_sfr_hit <= hit_nxt;
    end
  end

  // --------------------------------------------------------------
  // Decoders and registered select outputs
  // --------------------------------------------------------------
  cmpsel_neg_type neg0_nxt;
  cmpsel_neg_type neg1_nxt;
  cmpsel_pos_type pos0_nxt;
  cmpsel_pos_type pos1_nxt;

  // Decode the next register value so outputs track the register in the same cycle.
  cmpsel_decode #(.CONVERTER_AT_TOP(1'b0)) u_dec0 (
    .i_select(cmp0_sel_nxt),
    .o_neg(neg0_nxt),
    .o_pos(pos0_nxt)
  );
  cmpsel_decode #(.CONVERTER_AT_TOP(1'b1)) u_dec1 (
    .i_select(cmp1_sel_nxt),
    .o_neg(neg1_nxt),
    .o_pos(pos1_nxt)
  );

  // Select lines after reset show code 1111: ground, battery, ground, converter rail.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_cmp0_negative_select <= `CMPSEL_NEG_RESET;
      o_cmp0_positive_select <= `CMPSEL_POS0_RESET;
      o_cmp1_negative_select <= `CMPSEL_NEG_RESET;
      o_cmp1_positive_select <= `CMPSEL_POS1_RESET;
    end else begin
      o_cmp0_negative_select <= neg0_nxt;
      o_cmp0_positive_select <= pos0_nxt;
      o_cmp1_negative_select <= neg1_nxt;
      o_cmp1_positive_select <= pos1_nxt;
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // Field views of the stored registers for the checks below.
  logic [3:0] neg0_fld;
  logic [3:0] pos0_fld;
  logic [3:0] neg1_fld;
  logic [3:0] pos1_fld;
  assign neg0_fld = cmp0_sel_r[`CMPSEL_NEG_MSB:`CMPSEL_NEG_LSB];
  assign pos0_fld = cmp0_sel_r[`CMPSEL_POS_MSB:`CMPSEL_POS_LSB];
  assign neg1_fld = cmp1_sel_r[`CMPSEL_NEG_MSB:`CMPSEL_NEG_LSB];
  assign pos1_fld = cmp1_sel_r[`CMPSEL_POS_MSB:`CMPSEL_POS_LSB];

  // Storage of both registers, read-back of comparator0, and sample select map checks.
  cmp0_write_a: assert property (i_sfr_wr && sel0 |=> cmp0_sel_r == $past(i_sfr_wdata))
    else $error("comparator0 select did not store write");
  cmp1_write_a: assert property (i_sfr_wr && sel1 |=> cmp1_sel_r == $past(i_sfr_wdata))
    else $error("comparator1 select did not store write");
  read_back_a: assert property (i_sfr_rd && sel0 && !i_sfr_wr |=> o_sfr_rdata == cmp0_sel_r)
    else $error("comparator0 read back mismatch");
  neg0_ground_a: assert property (cmp0_sel_r[7:4] == 4'hf |-> o_cmp0_negative_select == 11'h400)
    else $error("comparator0 negative code f not ground");
  pos0_top_a: assert property (cmp0_sel_r[3:0] == 4'hf |-> o_cmp0_positive_select == 12'h400)
    else $error("comparator0 positive code f not battery");
  neg1_ref_a: assert property (cmp1_sel_r[7:4] == 4'hc |-> o_cmp1_negative_select == 11'h080)
    else $error("comparator1 negative code c not reference");
  pos1_rail_a: assert property (cmp1_sel_r[3:0] == 4'hf |-> o_cmp1_positive_select == 12'h800)
    else $error("comparator1 positive code f not converter rail");
  reserved_neg_a: assert property (cmp0_sel_r[7:5] == 3'h2 |-> o_cmp0_negative_select == 11'h000)
    else $error("reserved code drove a select line");
  onehot_pos_a: assert property ($onehot0(o_cmp1_positive_select))
    else $error("comparator1 positive select not one-hot");

  // Reset values seen at the first edge after reset.
  reset_regs_a: assert property (!$past(i_reset_n) |-> &{cmp0_sel_r, cmp1_sel_r})
    else $error("select registers not all ones after reset");
  reset_rail_a: assert property (!$past(i_reset_n) |-> o_cmp1_positive_select[11])
    else $error("comparator1 positive select not converter rail after reset");

  // Bus answers: one cycle of data and hit, refused accesses change nothing.
  read_back1_a: assert property (rd1_go && !i_sfr_wr |=> o_sfr_rdata == cmp1_sel_r)
    else $error("comparator1 read back mismatch");
  rdata_idle_a: assert property (!i_sfr_rd |=> o_sfr_rdata == 8'h00)
    else $error("read data not zero outside a read");
  hit_idle_a: assert property (!i_sfr_rd && !i_sfr_wr |=> !o_sfr_hit)
    else $error("hit raised without an access");
  refuse_wr0_a: assert property (i_sfr_wr && !sel0 |=> $stable(cmp0_sel_r))
    else $error("comparator0 select changed by a foreign write");
  refuse_wr1_a: assert property (i_sfr_wr && !sel1 |=> $stable(cmp1_sel_r))
    else $error("comparator1 select changed by a foreign write");

  // Comparator0 maps.
  neg0_supply_a: assert property (neg0_fld == 4'he |-> o_cmp0_negative_select == 11'h200)
    else $error("comparator0 negative code e not digital supply");
  neg0_ref_a: assert property (neg0_fld == 4'hc |-> o_cmp0_negative_select == 11'h080)
    else $error("comparator0 negative code c not reference");
  neg0_pin_a: assert property (neg0_fld == 4'h6 |-> o_cmp0_negative_select == 11'h008)
    else $error("comparator0 negative code 6 not its pin");
  pos0_batt_a: assert property (pos0_fld == 4'he |-> o_cmp0_positive_select == 12'h400)
    else $error("comparator0 positive code e not battery");
  pos0_pin_a: assert property (pos0_fld == 4'h8 |-> o_cmp0_positive_select == 12'h040)
    else $error("comparator0 positive code 8 not its pin");
  pos0_norail_a: assert property (!o_cmp0_positive_select[11])
    else $error("comparator0 positive select drove the converter rail");
  onehot_neg0_a: assert property ($onehot0(o_cmp0_negative_select))
    else $error("comparator0 negative select not one-hot");
  onehot_pos0_a: assert property ($onehot0(o_cmp0_positive_select))
    else $error("comparator0 positive select not one-hot");

  // Comparator1 maps.
  neg1_ground_a: assert property (neg1_fld == 4'hf |-> o_cmp1_negative_select == 11'h400)
    else $error("comparator1 negative code f not ground");
  pos1_batt_a: assert property (pos1_fld == 4'he |-> o_cmp1_positive_select == 12'h400)
    else $error("comparator1 positive code e not battery");
  pos1_pin_a: assert property (pos1_fld == 4'h3 |-> o_cmp1_positive_select == 12'h008)
    else $error("comparator1 positive code 3 not its pin");
  onehot_neg1_a: assert property ($onehot0(o_cmp1_negative_select))
    else $error("comparator1 negative select not one-hot");

  // Reserved codes drive nothing on comparator1 either.
  reserved_pos_a: assert property (pos1_fld inside {4'h4, 4'h5, 4'ha, 4'hb}
    |-> o_cmp1_positive_select == 12'h000)
    else $error("reserved positive code drove a select line");
  reserved_neg1_a: assert property (neg1_fld inside {4'h3, 4'h4, 4'h5, 4'ha, 4'hb}
    |-> o_cmp1_negative_select == 11'h000)
    else $error("reserved negative code drove a select line");

  cov_write0_c: cover property (i_sfr_wr && sel0);
  cov_write1_c: cover property (i_sfr_wr && sel1);
  cov_reserved_c: cover property (cmp1_sel_r[3:0] == 4'h4);
  cov_rdwr_c: cover property (rd1_go && wr1_go);
  cov_pin_c: cover property (o_cmp0_negative_select[0]);
endmodule // cmpsel_top
`default_nettype wire

//--- rtl/cmpsel_map.svh
// Register offsets, reset values and field positions of the comparator input select block.
`ifndef CMPSEL_MAP_SVH
`define CMPSEL_MAP_SVH
`define CMPSEL_SFR_PAGE 4'h0
`define CMPSEL_ADDR_CMP1 8'h9e
`define CMPSEL_ADDR_CMP0 8'h9f
`define CMPSEL_RESET_VALUE 8'hff
`define CMPSEL_NEG_RESET 11'h400
`define CMPSEL_POS0_RESET 12'h400
`define CMPSEL_POS1_RESET 12'h800
`define CMPSEL_NEG_MSB 7
`define CMPSEL_NEG_LSB 4
`define CMPSEL_POS_MSB 3
`define CMPSEL_POS_LSB 0
`endif

//--- rtl/cmpsel_pkg.sv
// Types shared by the comparator input select block.
package cmpsel_pkg;
  // One-hot select lines of a negative multiplexer.
  // Bits: 0 P0.1, 1 P0.3, 2 P0.5, 3 P1.5, 4 P1.7, 5 P2.1, 6 P2.3,
  // 7 compare reference, 8 battery halved, 9 digital supply, 10 ground.
  typedef logic [10:0] cmpsel_neg_type;
  // One-hot select lines of a positive multiplexer.
  // Bits: 0 P0.0, 1 P0.2, 2 P0.4, 3 P0.6, 4 P1.4, 5 P1.6, 6 P2.0, 7 P2.2,
  // 8 compare reference, 9 battery halved, 10 battery supply, 11 converter supply rail.
  typedef logic [11:0] cmpsel_pos_type;
endpackage

//--- rtl/cmpsel_decode.sv
// Decoder from one select register to the one-hot mux select lines.
`timescale 1ns/1ps
`default_nettype none
module cmpsel_decode #(
  parameter bit CONVERTER_AT_TOP = 1'b0
) (
  input wire logic [7:0] i_select,
  output logic [10:0] o_neg,
  output logic [11:0] o_pos
);
  // --------------------------------------------------------------
  // Field decoding
  // --------------------------------------------------------------
  logic [3:0] neg_code;
  logic [3:0] pos_code;
  assign neg_code = i_select[7:4];
  assign pos_code = i_select[3:0];

  // Negative map, identical for both comparators; reserved codes drive nothing.
  always_comb begin
    o_neg = 11'h000;
    unique case (neg_code)
      4'h0: o_neg[0] = 1'b1;
      4'h1: o_neg[1] = 1'b1;
      4'h2: o_neg[2] = 1'b1;
      4'h6: o_neg[3] = 1'b1;
      4'h7: o_neg[4] = 1'b1;
      4'h8: o_neg[5] = 1'b1;
      4'h9: o_neg[6] = 1'b1;
      4'hc: o_neg[7] = 1'b1;
      4'hd: o_neg[8] = 1'b1;
      4'he: o_neg[9] = 1'b1;
      4'hf: o_neg[10] = 1'b1;
      default: o_neg = 11'h000;
    endcase
  end

  // Positive map; code f picks the battery or the converter rail per instance.
  always_comb begin
    o_pos = 12'h000;
    unique case (pos_code)
      4'h0: o_pos[0] = 1'b1;
      4'h1: o_pos[1] = 1'b1;
      4'h2: o_pos[2] = 1'b1;
      4'h3: o_pos[3] = 1'b1;
      4'h6: o_pos[4] = 1'b1;
      4'h7: o_pos[5] = 1'b1;
      4'h8: o_pos[6] = 1'b1;
      4'h9: o_pos[7] = 1'b1;
      4'hc: o_pos[8] = 1'b1;
      4'hd: o_pos[9] = 1'b1;
      4'he: o_pos[10] = 1'b1;
      4'hf: begin
        if (CONVERTER_AT_TOP) begin
          o_pos[11] = 1'b1;
        end else begin
          o_pos[10] = 1'b1;
        end
      end
      default: o_pos = 12'h000;
    endcase
  end
endmodule // cmpsel_decode
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking testbench of the comparator input select block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cmpsel_pkg::*;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic [3:0] i_sfr_page = 4'h0;
  logic [7:0] i_sfr_addr = 8'h00;
  logic i_sfr_wr = 1'b0;
  logic i_sfr_rd = 1'b0;
  logic [7:0] i_sfr_wdata = 8'h00;
  logic [7:0] rdata;
  logic hit;
  cmpsel_neg_type n0, n1;
  cmpsel_pos_type p0, p1;
  int err_count = 0;
  int checks = 0;
  cmpsel_top dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_sfr_page(i_sfr_page),
    .i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
    .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
    .o_cmp0_negative_select(n0), .o_cmp0_positive_select(p0),
    .o_cmp1_negative_select(n1), .o_cmp1_positive_select(p1));
  // Clock of 25 ns period.
  initial begin
    forever #12.5 i_clk = ~i_clk;
  end
  // ----------------------------------------
  // Expected select lines and bus helpers
  // ----------------------------------------
  function automatic logic [10:0] en(input logic [3:0] c);
    case (c)
      4'h0, 4'h1, 4'h2: en = 11'h001 << c;
      4'h6, 4'h7, 4'h8, 4'h9: en = 11'h001 << (c - 4'h3);
      4'hc, 4'hd, 4'he, 4'hf: en = 11'h001 << (c - 4'h5);
      default: en = 11'h000;
    endcase
  endfunction
  function automatic logic [11:0] ep(input logic [3:0] c, input logic one);
    case (c)
      4'h0, 4'h1, 4'h2, 4'h3: ep = 12'h001 << c;
      4'h6, 4'h7, 4'h8, 4'h9: ep = 12'h001 << (c - 4'h2);
      4'hc, 4'hd, 4'he: ep = 12'h001 << (c - 4'h4);
      4'hf: ep = one ? 12'h800 : 12'h400;
      default: ep = 12'h000;
    endcase
  endfunction
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Writes one byte and judges the hit; an idle cycle follows so calls chain cleanly.
  task automatic wr(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d,
                    input logic h);
    i_sfr_page = pg;
    i_sfr_addr = a;
    i_sfr_wdata = d;
    i_sfr_wr = 1'b1;
    @(negedge i_clk);
    i_sfr_wr = 1'b0;
    cmp({11'h0, hit}, {11'h0, h});
    @(negedge i_clk);
  endtask
  // Reads one byte, judges the answer cycle, then checks that both answers drop.
  task automatic rd(input logic [3:0] pg, input logic [7:0] a, input logic [7:0] d, input logic h);
    i_sfr_page = pg;
    i_sfr_addr = a;
    i_sfr_rd = 1'b1;
    @(negedge i_clk);
    i_sfr_rd = 1'b0;
    cmp({4'h0, rdata}, {4'h0, d});
    cmp({11'h0, hit}, {11'h0, h});
    @(negedge i_clk);
    cmp({4'h0, rdata}, 12'h000);
    cmp({11'h0, hit}, 12'h000);
  endtask
  task automatic sel(input logic [7:0] v0, input logic [7:0] v1);
    cmp({1'b0, n0}, {1'b0, en(v0[7:4])});
    cmp(p0, ep(v0[3:0], 1'b0));
    cmp({1'b0, n1}, {1'b0, en(v1[7:4])});
    cmp(p1, ep(v1[3:0], 1'b1));
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    sel(8'hff, 8'hff);
    rd(4'h0, 8'h9f, 8'hff, 1'b1);
    rd(4'h0, 8'h9e, 8'hff, 1'b1);
  endtask
  // Every code of both fields, reserved ones included, written and read back.
  task automatic t_map();
    logic [7:0] v;
    for (int i = 0; i < 16; i++) begin
      v = {i[3:0], ~i[3:0]};
      wr(4'h0, 8'h9f, v, 1'b1);
      wr(4'h0, 8'h9e, ~v, 1'b1);
      sel(v, ~v);
      rd(4'h0, 8'h9f, v, 1'b1);
      rd(4'h0, 8'h9e, ~v, 1'b1);
    end
  endtask
  // Other page and other address are ignored; hit drops after one cycle.
  task automatic t_refuse();
    wr(4'h0, 8'h9f, 8'h12, 1'b1);
    wr(4'h1, 8'h9f, 8'h00, 1'b0);
    wr(4'h0, 8'h9d, 8'h00, 1'b0);
    rd(4'h1, 8'h9f, 8'h00, 1'b0);
    rd(4'h0, 8'h9d, 8'h00, 1'b0);
    rd(4'h0, 8'h9f, 8'h12, 1'b1);
    @(negedge i_clk);
    cmp({11'h0, hit}, 12'h000);
    sel(8'h12, 8'h0f);
  endtask
  // Read and write together return the old value; a second reset restores all ones.
  task automatic t_rdwr();
    i_sfr_page = 4'h0;
    i_sfr_addr = 8'h9e;
    i_sfr_wdata = 8'h3c;
    i_sfr_wr = 1'b1;
    i_sfr_rd = 1'b1;
    @(negedge i_clk);
    i_sfr_wr = 1'b0;
    i_sfr_rd = 1'b0;
    cmp({4'h0, rdata}, 12'h00f);
    cmp({11'h0, hit}, 12'h001);
    @(negedge i_clk);
    sel(8'h12, 8'h3c);
    rd(4'h0, 8'h9e, 8'h3c, 1'b1);
    i_reset_n = 1'b0;
    @(negedge i_clk);
    i_reset_n = 1'b1;
    t_reset();
  endtask
  task automatic give_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence after an eight cycle reset.
  initial begin
    repeat (8) @(negedge i_clk);
    i_reset_n = 1'b1;
    t_reset();
    t_map();
    t_refuse();
    t_rdwr();
    give_verdict();
  end
  // Watchdog well beyond the roughly 160 cycles the scenarios need.
  initial begin
    #50000;
    err_count++;
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
